// ===== include/sbp_pkg.sv
// package of constants for the sequential byte program sequencer
// assumes a serial flash core that runs on sys_clk at 100 MHz
//
// Function
// [RULE1] host sends write enable before the first sequential program opcode
// [RULE2] host targets only erased locations in sequential mode
// [RULE3] first transaction: opcode, 24-bit address, one data byte, msb first
// [RULE4] later transactions: opcode then one data byte, no address
// [RULE5] chip select release after first transaction starts program at given address
// [RULE6] later bytes program at the address counter without new write enable
// [RULE7] counter loads start address, then steps by one after each byte
// [RULE8] write disable ends the mode and clears the write enable latch
// [RULE9] busy flag is set while a byte program runs
// [RULE10] host polls status at the end of each program cycle
// [RULE11] while busy only a small set of commands is accepted
// [RULE12] in mode accept enable, disable, terminate, status, reset and id reads
// [RULE13] in mode accept further sequential program opcodes
// [RULE14] in mode reject every other command
// [RULE15] several data bytes in one transaction: only the last is programmed
// [RULE16] release off a byte boundary or before data aborts and clears the latch
// [RULE17] protected start address: no program, latch cleared
// [RULE18] after the last byte before a protected block leave mode, clear latch
// [RULE19] no wrap: after the last array byte leave mode, clear latch
// [RULE20] entering a block with suspended erase leaves the mode
// [RULE21] whenever the write enable latch clears, the mode ends
// [RULE22] a failed byte sets program and erase error flags
// [RULE23] busy sits at bit 0 of the first status register
package sbp_pkg;
   localparam logic [7:0] OP_SEQ_A     = 8'hAD;
   localparam logic [7:0] OP_SEQ_B     = 8'hAF;
   localparam logic [7:0] OP_WREN      = 8'h06;
   localparam logic [7:0] OP_WRDI      = 8'h04;
   localparam logic [7:0] OP_TERM      = 8'hF0;
   localparam logic [7:0] OP_RST_EN    = 8'h66;
   localparam logic [7:0] OP_RST       = 8'h99;
   localparam logic [7:0] OP_STAT1     = 8'h05;
   localparam logic [7:0] OP_STAT2     = 8'h35;
   localparam logic [7:0] OP_STAT3     = 8'h15;
   localparam logic [7:0] OP_STATX     = 8'h65;
   localparam logic [7:0] OP_ID_A      = 8'h9F;
   localparam logic [7:0] OP_ID_B      = 8'h90;
   localparam logic [7:0] OP_ID_C      = 8'h94;
   localparam int         ADDR_W       = 24;
   localparam int         BLK_LSB      = 16;
   localparam logic [23:0] LAST_ADDR   = 24'h07FFF;
   localparam int         NUM_BLK      = 8;
   localparam int         SR_BUSY_BIT  = 0;
   localparam int         SR_WEL_BIT   = 1;
   localparam int         CLK_PERIOD_NS        = 10;
   localparam int         BYTE_PROG_TIME_NS    = 8000;
   localparam int         BYTE_PROG_CYCLES     =
      (BYTE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] BYTES_INIT   = 3'h5;
   localparam logic [2:0] BYTES_NEXT   = 3'h2;
   typedef enum logic [1:0] {
      K_NONE = 2'b00,
      K_INIT = 2'b01,
      K_NEXT = 2'b10
   } sbp_kind_t;
   typedef enum logic [1:0] {
      E_IDLE  = 2'b00,
      E_WRITE = 2'b01,
      E_WAIT  = 2'b10
   } sbp_eng_t;
endpackage

// ===== include/sbp_prog_if.sv
// carrier between the sequencer and its byte program engine
// assumes both ends run on sys_clk
`timescale 1ns/100ps
`default_nettype none
interface sbp_prog_if;
   logic        start;
   logic [23:0] addr;
   logic [7:0]  data;
   logic        busy;
   logic        done;
   logic        fail;
   modport ctl (output start, output addr, output data,
                input busy, input done, input fail);
   modport eng (input start, input addr, input data,
                output busy, output done, output fail);
endinterface
`default_nettype wire

// ===== src/sbp_prog_engine.sv
// self-timed single byte program engine
// assumes the array takes array_we as a one-cycle write and reports array_fail
`timescale 1ns/100ps
`default_nettype none
module sbp_prog_engine
   import sbp_pkg::*;
#(
   parameter int PROG_CYCLES = BYTE_PROG_CYCLES
) (
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  rst,
   // sequencer side
   sbp_prog_if.eng    prog,
   // array side
   output logic       array_we,
   output logic [23:0] array_addr,
   output logic [7:0] array_data,
   input  wire logic  array_fail
);
   localparam int A_DONE_MAX = 1000;
   sbp_eng_t    state;
   logic [15:0] cnt;

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= E_IDLE;
         cnt   <= 16'h0000;
      end else begin
         case (state)
            E_IDLE: begin
               if (prog.start) begin
                  state <= E_WRITE;
               end
            end
            E_WRITE: begin
               state <= E_WAIT;
               cnt   <= 16'(PROG_CYCLES - 1);
            end
            E_WAIT: begin
               if (cnt == 16'h0000) begin
                  state <= E_IDLE;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            default: state <= E_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         array_addr <= 24'h000000;
         array_data <= 8'h00;
      end else if (prog.start && state == E_IDLE) begin
         array_addr <= prog.addr;
         array_data <= prog.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prog.done <= 1'b0;
         prog.fail <= 1'b0;
      end else begin
         prog.done <= (state == E_WAIT) && (cnt == 16'h0000);
         prog.fail <= (state == E_WAIT) && (cnt == 16'h0000) && array_fail;
      end
   end

   assign array_we  = (state == E_WRITE);
   assign prog.busy = (state != E_IDLE) || prog.start;  // [RULE9]

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_prog_time_bound: assert property (  // [RULE9]
      @(posedge sys_clk) disable iff (rst)
      (prog.start && state == E_IDLE) |=> prog.busy[*2] ##[1:A_DONE_MAX] prog.done)
      else $error("byte program did not finish in time");
endmodule
`default_nettype wire

// ===== src/sbp_seq_top.sv
// sequential byte program sequencer of a serial flash
// assumes spi pins arrive asynchronously and the array sits behind sbp_prog_engine
`timescale 1ns/100ps
`default_nettype none
module sbp_seq_top
   import sbp_pkg::*;
#(
   parameter int          BLKS     = NUM_BLK,
   parameter logic [23:0] LAST     = LAST_ADDR,
   parameter int          P_CYCLES = BYTE_PROG_CYCLES
) (
   // clock and reset
   input  wire logic            sys_clk,
   input  wire logic            rst,
   // serial pins
   input  wire logic            spi_sck,
   input  wire logic            spi_cs_n,
   input  wire logic            spi_si,
   // protection and suspend state, error flag clear
   input  wire logic [BLKS-1:0] block_protect,
   input  wire logic            erase_suspended,
   input  wire logic [7:0]      suspended_block,
   input  wire logic            error_clear,
   // array
   output logic                 array_we,
   output logic [23:0]          array_addr,
   output logic [7:0]           array_data,
   input  wire logic            array_fail,
   // status
   output logic [7:0]           first_status_register,
   output logic                 write_enable_latch,
   output logic                 busy_flag,
   output logic                 sequential_mode_flag,
   output logic                 program_error_flag,
   output logic                 erase_error_flag,
   output logic [23:0]          address_counter,
   output logic                 cmd_accept,
   output logic                 cmd_reject,
   output logic [7:0]           cmd_opcode
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic is_seq(input logic [7:0] op);
      return (op == OP_SEQ_A) || (op == OP_SEQ_B);
   endfunction

   function automatic logic ok_busy(input logic [7:0] op);
      return (op == OP_STAT1) || (op == OP_STAT2) || (op == OP_STAT3)
          || (op == OP_STATX) || (op == OP_TERM) || (op == OP_RST_EN)
          || (op == OP_RST);
   endfunction

   function automatic logic ok_mode(input logic [7:0] op);
      return ok_busy(op) || (op == OP_WREN) || (op == OP_WRDI)
          || (op == OP_ID_A) || (op == OP_ID_B) || (op == OP_ID_C);
   endfunction

   function automatic logic prot(input logic [23:0] a, input logic [BLKS-1:0] p);
      logic [7:0] b;
      b = a[BLK_LSB +: 8];
      return (int'(b) >= BLKS) ? 1'b1 : p[b[$clog2(BLKS)-1:0]];
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic sck_s1, sck_s2, sck_s3;
   logic cs_s1, cs_s2, cs_s3;
   logic si_s1, si_s2;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_s3 <= 1'b0;
         cs_s1  <= 1'b1;
         cs_s2  <= 1'b1;
         cs_s3  <= 1'b1;
         si_s1  <= 1'b0;
         si_s2  <= 1'b0;
      end else begin
         sck_s1 <= spi_sck;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         cs_s1  <= spi_cs_n;
         cs_s2  <= cs_s1;
         cs_s3  <= cs_s2;
         si_s1  <= spi_si;
         si_s2  <= si_s1;
      end
   end

   logic sck_rise, cs_rise, cs_low;
   assign sck_rise = sck_s2 && !sck_s3;
   assign cs_rise  = cs_s2 && !cs_s3;
   assign cs_low   = !cs_s2;

   // ----------------------------------------
   // bit and byte capture
   // ----------------------------------------
   logic [31:0] shreg;
   logic [2:0]  bit_cnt;
   logic [2:0]  byte_cnt;
   logic [23:0] start_addr;
   logic        bit_in;
   logic        op_done;
   logic [7:0]  next_op;

   assign bit_in  = sck_rise && cs_low;
   assign op_done = bit_in && bit_cnt == 3'h7 && byte_cnt == 3'h0;
   assign next_op = {shreg[6:0], si_s2};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shreg    <= 32'h00000000;
         bit_cnt  <= 3'h0;
         byte_cnt <= 3'h0;
      end else if (!cs_low) begin
         bit_cnt  <= 3'h0;
         byte_cnt <= 3'h0;
      end else if (bit_in) begin
         shreg   <= {shreg[30:0], si_s2};  // [RULE3] [RULE4]
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
            byte_cnt <= byte_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         start_addr <= 24'h000000;
      end else if (bit_in && bit_cnt == 3'h7 && byte_cnt == 3'h3) begin
         start_addr <= {shreg[22:0], si_s2};  // [RULE3]
      end
   end

   // ----------------------------------------
   // command classification
   // ----------------------------------------
   sbp_kind_t kind;
   logic      cmd_ok;
   logic      rst_armed;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         kind       <= K_NONE;
         cmd_ok     <= 1'b0;
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
         cmd_opcode <= 8'h00;
      end else begin
         cmd_accept <= 1'b0;
         cmd_reject <= 1'b0;
         if (cs_rise) begin
            kind   <= K_NONE;
            cmd_ok <= 1'b0;
         end else if (op_done) begin
            cmd_opcode <= next_op;
            kind       <= K_NONE;
            if (busy_flag) begin
               cmd_ok     <= ok_busy(next_op);  // [RULE11]
               cmd_accept <= ok_busy(next_op);
               cmd_reject <= !ok_busy(next_op);
            end else if (sequential_mode_flag) begin
               cmd_ok     <= ok_mode(next_op) || is_seq(next_op);  // [RULE12] [RULE13]
               cmd_accept <= ok_mode(next_op) || is_seq(next_op);
               cmd_reject <= !(ok_mode(next_op) || is_seq(next_op));  // [RULE14]
               if (is_seq(next_op)) begin
                  kind <= K_NEXT;  // [RULE4]
               end
            end else begin
               cmd_ok     <= 1'b1;
               cmd_accept <= 1'b1;
               if (is_seq(next_op) && write_enable_latch) begin
                  kind <= K_INIT;  // [RULE1]
               end
            end
         end
      end
   end

   // ----------------------------------------
   // end of transaction actions
   // ----------------------------------------
   logic on_byte, whole_cmd;
   logic init_go, next_go, seq_abort;
   logic wren_go, wel_drop, mode_exit;
   logic at_last, next_prot, next_susp;
   logic [23:0] cnt_inc;
   sbp_prog_if prog ();

   assign on_byte   = (bit_cnt == 3'h0);
   assign whole_cmd = cs_rise && cmd_ok && on_byte && byte_cnt != 3'h0;
   assign init_go   = cs_rise && kind == K_INIT && on_byte && byte_cnt >= BYTES_INIT
                      && !prot(start_addr, block_protect);  // [RULE5] [RULE17]
   assign next_go   = cs_rise && kind == K_NEXT && on_byte
                      && byte_cnt >= BYTES_NEXT;  // [RULE6]
   assign seq_abort = cs_rise && kind != K_NONE && !init_go && !next_go;  // [RULE16] [RULE17]

   assign cnt_inc   = address_counter + 24'h000001;
   assign at_last   = (address_counter == LAST);
   assign next_prot = prot(cnt_inc, block_protect);
   assign next_susp = erase_suspended && cnt_inc[BLK_LSB +: 8] == suspended_block;

   assign wren_go   = whole_cmd && cmd_opcode == OP_WREN;
   assign wel_drop  = seq_abort  // [RULE16]
                   || (whole_cmd && cmd_opcode == OP_WRDI)  // [RULE8]
                   || (whole_cmd && cmd_opcode == OP_TERM)
                   || (whole_cmd && cmd_opcode == OP_RST && rst_armed)
                   || (prog.done && sequential_mode_flag
                       && (at_last || next_prot));  // [RULE18] [RULE19]
   assign mode_exit = prog.done && next_susp;  // [RULE20]

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rst_armed <= 1'b0;
      end else if (whole_cmd) begin
         rst_armed <= (cmd_opcode == OP_RST_EN);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         write_enable_latch <= 1'b0;
      end else if (wren_go) begin
         write_enable_latch <= 1'b1;
      end else if (wel_drop) begin
         write_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sequential_mode_flag <= 1'b0;
      end else if (!write_enable_latch || wel_drop || mode_exit) begin
         sequential_mode_flag <= 1'b0;  // [RULE21]
      end else if (init_go) begin
         sequential_mode_flag <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         address_counter <= 24'h000000;
      end else if (init_go) begin
         address_counter <= start_addr;  // [RULE7]
      end else if (prog.done && !at_last) begin
         address_counter <= cnt_inc;  // [RULE7] [RULE19]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         program_error_flag <= 1'b0;
         erase_error_flag   <= 1'b0;
      end else if (prog.fail) begin
         program_error_flag <= 1'b1;  // [RULE22]
         erase_error_flag   <= 1'b1;
      end else if (error_clear) begin
         program_error_flag <= 1'b0;
         erase_error_flag   <= 1'b0;
      end
   end

   // ----------------------------------------
   // program engine
   // ----------------------------------------
   assign prog.start = init_go || next_go;
   assign prog.addr  = init_go ? start_addr : address_counter;
   assign prog.data  = shreg[7:0];  // [RULE15]

   sbp_prog_engine #(
      .PROG_CYCLES (P_CYCLES)
   ) u_engine (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .prog       (prog),
      .array_we   (array_we),
      .array_addr (array_addr),
      .array_data (array_data),
      .array_fail (array_fail)
   );

   assign busy_flag = prog.busy;  // [RULE9]

   always_comb begin
      first_status_register = 8'h00;
      first_status_register[SR_BUSY_BIT] = busy_flag;  // [RULE23]
      first_status_register[SR_WEL_BIT]  = write_enable_latch;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_mode_needs_wel: assert property (  // [RULE21]
      @(posedge sys_clk) disable iff (rst)
      !write_enable_latch |=> !sequential_mode_flag)
      else $error("mode kept without write enable latch");

   a_counter_load: assert property (  // [RULE7]
      @(posedge sys_clk) disable iff (rst)
      init_go |=> address_counter == $past(start_addr) && sequential_mode_flag)
      else $error("counter not loaded from start address");

   a_counter_step: assert property (  // [RULE7]
      @(posedge sys_clk) disable iff (rst)
      (prog.done && !at_last && !init_go)
         |=> address_counter == $past(address_counter) + 24'h000001)
      else $error("counter did not step by one");

   a_partial_abort: assert property (  // [RULE16]
      @(posedge sys_clk) disable iff (rst)
      (cs_rise && kind != K_NONE && !on_byte) |-> !prog.start ##1 !write_enable_latch)
      else $error("partial byte did not abort");

   a_last_exit: assert property (  // [RULE19]
      @(posedge sys_clk) disable iff (rst)
      (prog.done && at_last && sequential_mode_flag)
         |=> !write_enable_latch && !sequential_mode_flag)
      else $error("no exit after last array byte");

   a_wrdi_clears: assert property (  // [RULE8]
      @(posedge sys_clk) disable iff (rst)
      (whole_cmd && cmd_opcode == OP_WRDI) |=> !write_enable_latch ##1 !sequential_mode_flag)
      else $error("write disable left latch or mode set");

   a_fail_flags: assert property (  // [RULE22]
      @(posedge sys_clk) disable iff (rst)
      prog.fail |=> program_error_flag && erase_error_flag)
      else $error("program failure not flagged");

   a_busy_reject: assert property (  // [RULE11]
      @(posedge sys_clk) disable iff (rst)
      (op_done && busy_flag && is_seq(next_op)) |=> cmd_reject && kind == K_NONE)
      else $error("sequential opcode taken while busy");

   a_mode_reject: assert property (  // [RULE14]
      @(posedge sys_clk) disable iff (rst)
      (op_done && !busy_flag && sequential_mode_flag && next_op == 8'h03) |=> cmd_reject)
      else $error("array read accepted in sequential mode");

   a_busy_bit: assert property (  // [RULE23]
      @(posedge sys_clk) disable iff (rst)
      prog.start |=> first_status_register[0] [*3])
      else $error("busy bit not shown while programming");
endmodule
`default_nettype wire

// ===== verif/sbp_host_model.sv
// spi host model that drives the serial pins of the sequencer
// assumes sys_clk at 100 MHz; sck (80 ns) runs only inside frames, mode 0
`timescale 1ns/100ps
`default_nettype none
module sbp_host_model (
   // clock
   input  wire logic sys_clk,
   // serial pins
   output logic      spi_sck,
   output logic      spi_cs_n,
   output logic      spi_si
);
   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_si   = 1'b0;
   end
   // ------------------------------------------------
   // one frame: n bits from w[n-1:0], msb first
   // ------------------------------------------------
   task automatic xfer(input logic [47:0] w, input int n);
      @(negedge sys_clk);
      spi_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_si = w[i];
         repeat (4) @(negedge sys_clk);
         spi_sck = 1'b1;
         repeat (4) @(negedge sys_clk);
         spi_sck = 1'b0;
      end
      repeat (4) @(negedge sys_clk);
      spi_cs_n = 1'b1;
      spi_si   = ~spi_si;
      repeat (8) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// ===== verif/sbp_seq_top_tb.sv
// self-checking bench of the sequential byte program sequencer
// assumes sbp_host_model drives the pins; array is modelled by a write log
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module sbp_seq_top_tb;
   import sbp_pkg::*;
   localparam logic [23:0] TB_LAST = 24'h02FFFF;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  block_protect = 8'h00;
   logic        erase_suspended = 1'b0;
   logic [7:0]  suspended_block = 8'h02;
   logic        error_clear = 1'b0;
   logic        array_fail = 1'b0;
   logic        spi_sck, spi_cs_n, spi_si, array_we, write_enable_latch, busy_flag;
   logic        sequential_mode_flag, program_error_flag, erase_error_flag;
   logic        cmd_accept, cmd_reject;
   logic [23:0] array_addr, address_counter, w_addr;
   logic [7:0]  array_data, first_status_register, cmd_opcode, w_data;
   int          n_errors = 0, check_count = 0, n_we = 0, n_acc = 0, n_rej = 0, a, r;
   logic [7:0]  ok_ops [7] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'h9F, 8'h90, 8'h94};
   logic [7:0]  no_ops [9] = '{8'h03, 8'h20, 8'h60, 8'h02, 8'h75, 8'h36, 8'h01, 8'h5A, 8'h77};
   logic [23:0] ea [3] = '{24'h00FFFF, 24'h01FFFF, TB_LAST};
   always #5 sys_clk = ~sys_clk;
   sbp_host_model host (.sys_clk(sys_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
                        .spi_si(spi_si));
   sbp_seq_top #(.LAST(TB_LAST), .P_CYCLES(200)) dut (
      .sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .block_protect(block_protect), .erase_suspended(erase_suspended),
      .suspended_block(suspended_block), .error_clear(error_clear),
      .array_we(array_we), .array_addr(array_addr), .array_data(array_data),
      .array_fail(array_fail), .first_status_register(first_status_register),
      .write_enable_latch(write_enable_latch), .busy_flag(busy_flag),
      .sequential_mode_flag(sequential_mode_flag),
      .program_error_flag(program_error_flag), .erase_error_flag(erase_error_flag),
      .address_counter(address_counter), .cmd_accept(cmd_accept),
      .cmd_reject(cmd_reject), .cmd_opcode(cmd_opcode));
   // ------------------------------------------------
   // array write log and command pulse counts
   // ------------------------------------------------
   always @(posedge sys_clk) begin
      if (array_we === 1'b1) begin
         n_we++;
         w_addr = array_addr;
         w_data = array_data;
      end
      if (cmd_accept === 1'b1) n_acc++;
      if (cmd_reject === 1'b1) n_rej++;
   end
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic op(input logic [7:0] c);
      host.xfer({40'h0, c}, 8);
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy_flag !== 1'b0 && k < 2000) begin
         @(negedge sys_clk);
         k++;
      end
      @(negedge sys_clk);
      `CHK(busy_flag, 1'b0)
   endtask
   task automatic start(input logic [23:0] ad, input logic [7:0] d);
      op(OP_WREN);
      host.xfer({8'h00, OP_SEQ_A, ad, d}, 40);
   endtask
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------------------
   // scenarios; each address is used once, so it is erased
   // ------------------------------------------------
   task automatic t_init;
      start(24'h000010, 8'hA5);
      `CHK(first_status_register[SR_BUSY_BIT], 1'b1)
      wait_idle();
      `CHK(n_we, 1)
      `CHK(w_addr, 24'h000010)
      `CHK(w_data, 8'hA5)
      `CHK(sequential_mode_flag, 1'b1)
      `CHK(address_counter, 24'h000011)
   endtask
   task automatic t_next;
      a = n_acc;
      r = n_rej;
      host.xfer({24'h0, OP_SEQ_B, 8'h77, 8'h3C}, 24);
      op(OP_WREN);
      op(OP_SEQ_A);
      `CHK(n_rej, r + 2)
      wait_idle();
      `CHK(n_acc, a + 1)
      `CHK(w_addr, 24'h000011)
      `CHK(w_data, 8'h3C)
      `CHK(address_counter, 24'h000012)
   endtask
   task automatic t_gate;
      foreach (ok_ops[i]) begin
         a = n_acc;
         op(ok_ops[i]);
         `CHK(n_acc, a + 1)
      end
      foreach (no_ops[i]) begin
         r = n_rej;
         op(no_ops[i]);
         `CHK(n_rej, r + 1)
         `CHK(cmd_opcode, no_ops[i])
      end
      `CHK(sequential_mode_flag, 1'b1)
      op(OP_WRDI);
      `CHK(write_enable_latch, 1'b0)
      `CHK(sequential_mode_flag, 1'b0)
   endtask
   task automatic t_exit;
      start(24'h000400, 8'h22);
      wait_idle();
      a = n_acc;
      op(OP_WREN);
      `CHK(n_acc, a + 1)
      op(OP_RST);
      `CHK(write_enable_latch, 1'b1)
      `CHK(sequential_mode_flag, 1'b1)
      op(OP_TERM);
      `CHK(write_enable_latch, 1'b0)
      `CHK(sequential_mode_flag, 1'b0)
      start(24'h000500, 8'h33);
      wait_idle();
      op(OP_RST_EN);
      op(OP_RST);
      `CHK(write_enable_latch, 1'b0)
      `CHK(sequential_mode_flag, 1'b0)
   endtask
   task automatic t_abort;
      start(24'h000100, 8'h11);
      wait_idle();
      a = n_we;
      host.xfer({35'h0, OP_SEQ_B, 5'h15}, 13);
      `CHK(n_we, a)
      `CHK(write_enable_latch, 1'b0)
      `CHK(sequential_mode_flag, 1'b0)
   endtask
   task automatic t_prot;
      block_protect = 8'h01;
      a = n_we;
      start(24'h000200, 8'h01);
      `CHK(n_we, a)
      `CHK(write_enable_latch, 1'b0)
      block_protect = 8'h00;
   endtask
   task automatic t_edges;
      for (int i = 0; i < 3; i++) begin
         block_protect = (i == 0) ? 8'h02 : 8'h00;
         erase_suspended = (i == 1);
         start(ea[i], 8'h5A);
         wait_idle();
         repeat (3) @(negedge sys_clk);
         `CHK(w_addr, ea[i])
         `CHK(sequential_mode_flag, 1'b0)
         if (i != 1) `CHK(write_enable_latch, 1'b0)
         op(OP_WRDI);
      end
      block_protect = 8'h00;
      erase_suspended = 1'b0;
   endtask
   task automatic t_fail;
      array_fail = 1'b1;
      start(24'h000300, 8'h00);
      wait_idle();
      array_fail = 1'b0;
      `CHK(program_error_flag, 1'b1)
      `CHK(erase_error_flag, 1'b1)
      error_clear = 1'b1;
      @(negedge sys_clk);
      error_clear = 1'b0;
      @(negedge sys_clk);
      `CHK(program_error_flag, 1'b0)
      `CHK(erase_error_flag, 1'b0)
      op(OP_WRDI);
   endtask
   // ------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      repeat (5) @(negedge sys_clk);
      `CHK(first_status_register, 8'h00)
      t_init();
      t_next();
      t_gate();
      t_exit();
      t_abort();
      t_prot();
      t_edges();
      t_fail();
      end_of_test();
   end
   initial begin
      #500000;
      n_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
